//--- ocs_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - polarity 0..3: bit0 inverts digital output one, bit1 digital output two
// RULE_02 - level fraction 0.0..0.9 in tenths is added to the integer level
// RULE_03 - ready selection: on with power and ready, off on power loss or fault
// RULE_04 - speed reached: on at commanded frequency, band 0.5 Hz above, 1.0 Hz below
// RULE_05 - code 2 follows motor powered, no delay
// RULE_06 - code 3 follows reverse command, no delay
// RULE_07 - code 4 follows motor overload with 100 ms on and off delay
// RULE_08 - code 5 follows ramp regulator active with 100 ms delay
// RULE_09 - code 6: output frequency above level, 100 ms delay
// RULE_10 - code 7: output current percent above level, 100 ms delay
// RULE_11 - code 8: dc bus voltage above level, 100 ms delay
// RULE_12 - code 9: restart attempts exceeded, no delay
// RULE_13 - code 10: unipolar voltage input above level, 100 ms; unused when bipolar
// RULE_14 - power factor angle above level, 100 ms delay
// RULE_15 - code 12: input loss on at 2 mA or 1 V, off at 3 mA or 1.5 V
// RULE_16 - code 13: level zero turns off, one or more turns on
// RULE_17 - code 14: retries exceeded, restart disabled, or unrecoverable trip
// RULE_18 - code 15 follows brake coil control
// RULE_19 - thermal counter above level, or drive within 5 C of trip point
// RULE_20 - code 17 follows control module overheat
// RULE_21 - local active: any start source selects keypad
// RULE_22 - code 20 follows logic input one
// RULE_23 - each relay has its own selector and level, evaluated separately
module ocs_top
    import ocs_pkg::*;
#(
    parameter int unsigned DELAY_CYC = DELAY_CYC_DEF
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // drive status flags
    input wire logic power_ok,
    input wire logic drive_ready,
    input wire logic fault_active,
    input wire logic motor_powered,
    input wire logic reverse_cmd,
    input wire logic overload_active,
    input wire logic ramp_reg_active,
    input wire logic restart_exceeded,
    input wire logic unrecoverable_trip,
    input wire logic brake_coil_control,
    input wire logic control_module_overheat,
    input wire logic comm_loss,
    input wire logic logic_in1,
    // measured values, tenths of their unit
    input wire logic [15:0] out_freq,
    input wire logic [15:0] cmd_freq,
    input wire logic [15:0] out_current,
    input wire logic [15:0] dc_bus_volts,
    input wire logic [15:0] analog_v,
    input wire logic [15:0] analog_v_mag,
    input wire logic [15:0] analog_ma,
    input wire logic [15:0] pf_angle,
    input wire logic [15:0] thermal_count,
    input wire logic [15:0] drive_temp,
    input wire logic [15:0] trip_temp,
    // outputs
    output logic relay1_out,
    output logic relay2_out,
    output logic digital_out1,
    output logic digital_out2
);
    function automatic logic [31:0] ocs_merge(input logic [31:0] old, input logic [31:0] wd,
        input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res & mask;
    endfunction

    logic [31:0] ch_q [0:3];
    logic [31:0] ctrl_q;
    logic [NUM_CH-1:0] st;
    logic [3:0] out_q;
    logic [3:0] out_d;
    logic at_freq_q;
    logic at_freq_d;
    logic loss_q;
    logic loss_d;

    // write channel state
    ocs_wstate_t ws_q;
    logic awready_q;
    logic wready_q;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    // read channel state
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // bus decode
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic got_aw;
    logic got_w;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [5:0] wr_idx;
    logic wr_hit;
    logic wr_ctrl;
    logic [5:0] rd_idx;
    logic rd_hit;
    logic rd_ch;
    logic [31:0] rd_word;
    logic [31:0] stat_w;
    logic [31:0] ctrl_mrg;

    assign aw_hs = awvalid && awready_q;
    assign w_hs = wvalid && wready_q;
    assign ar_hs = arvalid && arready_q;
    assign got_aw = aw_hs || aw_have_q;
    assign got_w = w_hs || w_have_q;
    assign wr_en = (ws_q == WS_COLLECT) && got_aw && got_w;
    assign wr_addr = aw_have_q ? aw_addr_q : awaddr;
    assign wr_data = w_have_q ? w_data_q : wdata;
    assign wr_strb = w_have_q ? w_strb_q : wstrb;
    assign wr_idx = wr_addr[7:2];
    assign wr_hit = wr_idx <= ADDR_STAT[7:2];
    assign wr_ctrl = wr_en && (wr_idx == ADDR_CTRL[7:2]);
    assign ctrl_mrg = ocs_merge(ctrl_q, wr_data, wr_strb, CTRL_WMASK);
    assign rd_idx = araddr[7:2];
    assign rd_hit = rd_idx <= ADDR_STAT[7:2];
    assign rd_ch = rd_idx < ADDR_CTRL[7:2];
    assign rd_word = rd_ch ? ch_q[rd_idx[1:0]] :
        (rd_idx == ADDR_CTRL[7:2]) ? ctrl_q :
        (rd_idx == ADDR_STAT[7:2]) ? stat_w : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ws_q <= WS_COLLECT;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (ce) begin
            case (ws_q)
                WS_COLLECT: begin
                    awready_q <= !got_aw;
                    wready_q <= !got_w;
                    aw_have_q <= got_aw && !wr_en;
                    w_have_q <= got_w && !wr_en;
                    if (aw_hs) begin
                        aw_addr_q <= awaddr;
                    end
                    if (w_hs) begin
                        w_data_q <= wdata;
                        w_strb_q <= wstrb;
                    end
                    if (wr_en) begin
                        ws_q <= WS_RESP;
                        bvalid_q <= 1'b1;
                        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WS_RESP: begin
                    awready_q <= bready;
                    wready_q <= bready;
                    if (bready) begin
                        bvalid_q <= 1'b0;
                        ws_q <= WS_COLLECT;
                    end
                end
                default: ws_q <= WS_COLLECT;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            arready_q <= rvalid_q ? rready : !ar_hs;
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
        end else if (ce && wr_ctrl) begin
            ctrl_q <= ctrl_mrg;
        end
    end

    // shared conditions
    logic [16:0] fx;
    logic [16:0] cx;
    logic at_on;
    logic at_off;
    logic loss_set;
    logic loss_clr;
    logic temp_near;
    logic local_act;
    logic nonrec;
    logic ready_cond;
    logic [20:0] flags;

    assign fx = {1'b0, out_freq};
    assign cx = {1'b0, cmd_freq};
    assign at_on = (fx >= cx) && (fx <= cx + AT_ABOVE); // RULE_04
    assign at_off = (fx + AT_BELOW < cx) || (fx > cx + AT_ABOVE); // RULE_04
    assign at_freq_d = at_freq_q ? !at_off : at_on;
    assign loss_set = (ctrl_q[VLOSS_BIT] && (analog_v_mag <= LOSS_V_ON))
        || (ctrl_q[MALOSS_BIT] && (analog_ma <= LOSS_MA_ON)); // RULE_15
    assign loss_clr = !(ctrl_q[VLOSS_BIT] && (analog_v_mag < LOSS_V_OFF))
        && !(ctrl_q[MALOSS_BIT] && (analog_ma < LOSS_MA_OFF)); // RULE_15
    assign loss_d = loss_q ? !loss_clr : loss_set;
    assign temp_near = {1'b0, drive_temp} + TEMP_MARGIN >= {1'b0, trip_temp}; // RULE_19
    assign local_act = (ctrl_q[SS_LSB +: SS_W] == KEYPAD_SRC)
        || (ctrl_q[SS_LSB + SS_W +: SS_W] == KEYPAD_SRC)
        || (ctrl_q[SS_LSB + 2 * SS_W +: SS_W] == KEYPAD_SRC); // RULE_21
    assign nonrec = restart_exceeded || (ctrl_q[RST_LSB +: RST_W] == 8'h00) || unrecoverable_trip; // RULE_17
    assign ready_cond = power_ok && drive_ready && !fault_active; // RULE_03
    assign stat_w = {24'h000000, local_act, nonrec, loss_q, at_freq_q, out_q};

    always_comb begin
        flags = '0;
        flags[C_READY] = ready_cond; // RULE_03
        flags[C_SPEED] = at_freq_q; // RULE_04
        flags[C_POWERED] = motor_powered; // RULE_05
        flags[C_REVERSE] = reverse_cmd; // RULE_06
        flags[C_OVERLOAD] = overload_active; // RULE_07
        flags[C_RAMP] = ramp_reg_active; // RULE_08
        flags[C_RETRY] = restart_exceeded; // RULE_12
        flags[C_LOSS] = loss_q; // RULE_15
        flags[C_NONREC] = nonrec; // RULE_17
        flags[C_BRAKE] = brake_coil_control; // RULE_18
        flags[C_OVERHEAT] = control_module_overheat; // RULE_20
        flags[C_LOCAL] = local_act; // RULE_21
        flags[C_COMM] = comm_loss;
        flags[C_LOGIC1] = logic_in1; // RULE_22
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            at_freq_q <= 1'b0;
            loss_q <= 1'b0;
            out_q <= 4'h0;
        end else if (ce) begin
            at_freq_q <= at_freq_d;
            loss_q <= loss_d;
            out_q <= out_d;
        end
    end

    // normally closed polarity inverts the digital outputs only
    assign out_d = {st[3] ^ ctrl_q[POL_LSB + 1], st[2] ^ ctrl_q[POL_LSB], st[1], st[0]}; // RULE_01

    // one evaluator per relay and digital output
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [31:0] mrg;
        logic [31:0] ch_d;
        ocs_chan_if chif ();

        assign mrg = ocs_merge(ch_q[i], wr_data, wr_strb, CH_WMASK);
        always_comb begin
            ch_d = mrg;
            if (mrg[FRC_LSB +: FRC_W] > FRAC_MAX) begin
                ch_d[FRC_LSB +: FRC_W] = FRAC_MAX; // RULE_02
            end
            if (mrg[LVL_LSB +: LVL_W] > LVL_MAX) begin
                ch_d[LVL_LSB +: LVL_W] = LVL_MAX;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ch_q[i] <= CH_RST[i];
            end else if (ce && wr_en && (wr_idx == 6'(i))) begin
                ch_q[i] <= ch_d; // RULE_23
            end
        end

        assign chif.sel = ch_q[i][SEL_LSB +: SEL_W];
        assign chif.lvl = ch_q[i][LVL_LSB +: LVL_W];
        assign chif.frac = ch_q[i][FRC_LSB +: FRC_W];
        assign chif.flags = flags;
        assign chif.freq = out_freq;
        assign chif.curr = out_current;
        assign chif.dcv = dc_bus_volts;
        assign chif.anv = analog_v;
        assign chif.pfa = pf_angle;
        assign chif.therm = thermal_count;
        assign chif.bipolar = ctrl_q[BIP_BIT]; // RULE_13
        assign chif.temp_near = temp_near;
        assign st[i] = chif.state;

        ocs_chan #(
            .DELAY_CYC(DELAY_CYC)
        ) u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .ch(chif)
        );
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign relay1_out = out_q[0];
    assign relay2_out = out_q[1];
    assign digital_out1 = out_q[2];
    assign digital_out2 = out_q[3];

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    pol_out_a: assert property (ce |=> (digital_out1 == ($past(st[2]) ^ $past(ctrl_q[POL_LSB])))) // RULE_01
        else $error("digital output one polarity wrong");
    frac_range_a: assert property ((ch_q[0][FRC_LSB +: FRC_W] <= FRAC_MAX) && (ch_q[2][FRC_LSB +: FRC_W] <= FRAC_MAX)) // RULE_02
        else $error("level fraction above nine tenths");
    ready_off_a: assert property ((ce && ch_q[0][SEL_LSB +: SEL_W] == C_READY && fault_active) [*3] |-> !relay1_out) // RULE_03
        else $error("ready relay on during fault");
    speed_rise_a: assert property ($rose(at_freq_q) |-> $past(at_on)) // RULE_04
        else $error("speed reached set outside band");
    speed_fall_a: assert property ($fell(at_freq_q) |-> $past(at_off)) // RULE_04
        else $error("speed reached cleared inside band");
    loss_rise_a: assert property ($rose(loss_q) |-> $past(loss_set)) // RULE_15
        else $error("input loss set above threshold");
    direct_on_a: assert property ((ce && ch_q[0][SEL_LSB +: SEL_W] == C_DIRECT
        && ch_q[0][LVL_LSB +: LVL_W] != '0) [*3] |-> relay1_out) // RULE_16
        else $error("direct level relay not on");
    nonrec_on_a: assert property ((ce && ch_q[0][SEL_LSB +: SEL_W] == C_NONREC && nonrec) [*3] |-> relay1_out) // RULE_17
        else $error("unrecoverable relay not on");
    local_on_a: assert property ((ce && ch_q[0][SEL_LSB +: SEL_W] == C_LOCAL && local_act) [*3] |-> relay1_out) // RULE_21
        else $error("local active relay not on");
    bvalid_hold_a: assert property ((bvalid && !bready) |=> bvalid)
        else $error("write response dropped early");

    relay_rise_c: cover property ($rose(relay1_out));
    speed_rise_c: cover property ($rose(at_freq_q));
    loss_rise_c: cover property ($rose(loss_q));
    write_done_c: cover property (bvalid && bready);
endmodule

//--- ocs_pkg.sv
package ocs_pkg;
    // register map, channel n at ADDR_CH0 + 4*n (0,1 relays; 2,3 digital outputs)
    localparam logic [7:0] ADDR_CH0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam int NUM_CH = 4;
    // channel word fields
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 5;
    localparam int LVL_LSB = 8;
    localparam int LVL_W = 14;
    localparam int FRC_LSB = 24;
    localparam int FRC_W = 4;
    // control word fields
    localparam int POL_LSB = 0;
    localparam int BIP_BIT = 2;
    localparam int VLOSS_BIT = 3;
    localparam int MALOSS_BIT = 4;
    localparam int RST_LSB = 8;
    localparam int RST_W = 8;
    localparam int SS_LSB = 16;
    localparam int SS_W = 3;
    localparam logic [31:0] CH_WMASK = 32'h0f3fff1f;
    localparam logic [31:0] CTRL_WMASK = 32'h01ffff1f;
    // reset values
    localparam logic [31:0] CH_RST [0:3] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0002, 32'h0000_0002};
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] FRAC_MAX = 4'h9;
    localparam logic [13:0] LVL_MAX = 14'h270f;
    localparam logic [16:0] LVL_SCALE = 17'h0000a;
    // condition codes
    localparam logic [4:0] C_READY = 5'h00;
    localparam logic [4:0] C_SPEED = 5'h01;
    localparam logic [4:0] C_POWERED = 5'h02;
    localparam logic [4:0] C_REVERSE = 5'h03;
    localparam logic [4:0] C_OVERLOAD = 5'h04;
    localparam logic [4:0] C_RAMP = 5'h05;
    localparam logic [4:0] C_FREQ = 5'h06;
    localparam logic [4:0] C_CURR = 5'h07;
    localparam logic [4:0] C_DCV = 5'h08;
    localparam logic [4:0] C_RETRY = 5'h09;
    localparam logic [4:0] C_ANV = 5'h0a;
    localparam logic [4:0] C_PFA = 5'h0b;
    localparam logic [4:0] C_LOSS = 5'h0c;
    localparam logic [4:0] C_DIRECT = 5'h0d;
    localparam logic [4:0] C_NONREC = 5'h0e;
    localparam logic [4:0] C_BRAKE = 5'h0f;
    localparam logic [4:0] C_THERM = 5'h10;
    localparam logic [4:0] C_OVERHEAT = 5'h11;
    localparam logic [4:0] C_LOCAL = 5'h12;
    localparam logic [4:0] C_COMM = 5'h13;
    localparam logic [4:0] C_LOGIC1 = 5'h14;
    localparam logic [4:0] NUM_COND = 5'h15;
    localparam logic [20:0] DELAY_MASK = 21'h000df0;
    // timing: 100 ms on/off delay at 100 MHz
    localparam int DELAY_MS = 100;
    localparam int CLK_KHZ = 100000;
    localparam int DELAY_CYC_DEF = DELAY_MS * CLK_KHZ;
    localparam int CNT_W = 24;
    // thresholds in tenths of their unit
    localparam logic [16:0] AT_ABOVE = 17'h00005;
    localparam logic [16:0] AT_BELOW = 17'h0000a;
    localparam logic [15:0] LOSS_MA_ON = 16'h0014;
    localparam logic [15:0] LOSS_MA_OFF = 16'h001e;
    localparam logic [15:0] LOSS_V_ON = 16'h000a;
    localparam logic [15:0] LOSS_V_OFF = 16'h000f;
    localparam logic [16:0] TEMP_MARGIN = 17'h00032;
    localparam logic [2:0] KEYPAD_SRC = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic {WS_COLLECT, WS_RESP} ocs_wstate_t;
endpackage

//--- ocs_chan_if.sv
`timescale 1ns/10ps
interface ocs_chan_if;
    logic [4:0] sel;
    logic [13:0] lvl;
    logic [3:0] frac;
    logic [20:0] flags;
    logic [15:0] freq;
    logic [15:0] curr;
    logic [15:0] dcv;
    logic [15:0] anv;
    logic [15:0] pfa;
    logic [15:0] therm;
    logic bipolar;
    logic temp_near;
    logic state;
    modport ctrl (output sel, lvl, frac, flags, freq, curr, dcv, anv, pfa, therm, bipolar, temp_near,
        input state);
    modport chan (input sel, lvl, frac, flags, freq, curr, dcv, anv, pfa, therm, bipolar, temp_near,
        output state);
endinterface

//--- ocs_chan.sv
`timescale 1ns/10ps
module ocs_chan
    import ocs_pkg::*;
#(
    parameter int unsigned DELAY_CYC = DELAY_CYC_DEF
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // channel carrier
    ocs_chan_if.chan ch
);
    logic [16:0] cmp;
    logic known;
    logic delayed;
    logic expire;
    logic raw;
    logic st_q;
    logic st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // level in tenths: integer part plus fraction
    assign cmp = 17'(ch.lvl) * LVL_SCALE + 17'(ch.frac); // RULE_02 RULE_23
    assign known = ch.sel < NUM_COND;
    assign delayed = known && DELAY_MASK[ch.sel];
    assign expire = cnt_q == CNT_W'(DELAY_CYC - 1);

    always_comb begin
        case (ch.sel)
            C_FREQ: raw = {1'b0, ch.freq} > cmp; // RULE_09
            C_CURR: raw = {1'b0, ch.curr} > cmp; // RULE_10
            C_DCV: raw = {1'b0, ch.dcv} > cmp; // RULE_11
            C_ANV: raw = !ch.bipolar && ({1'b0, ch.anv} > cmp); // RULE_13
            C_PFA: raw = {1'b0, ch.pfa} > cmp; // RULE_14
            C_DIRECT: raw = ch.lvl != '0; // RULE_16
            C_THERM: raw = ({1'b0, ch.therm} > cmp) || ch.temp_near; // RULE_19
            default: raw = known && ch.flags[ch.sel];
        endcase
    end

    // delayed codes flip only after a full delay of mismatch
    assign st_d = ((raw != st_q) && (!delayed || expire)) ? raw : st_q; // RULE_07 RULE_08
    assign cnt_d = ((raw == st_q) || !delayed || expire) ? '0 : cnt_q + 1'b1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= 1'b0;
            cnt_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign ch.state = st_q;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    nodelay_follow_a: assert property ((ce && !delayed && raw != st_q) |=> (st_q == $past(raw))) // RULE_05
        else $error("undelayed condition not followed next cycle");
    delay_hold_a: assert property ((ce && delayed && raw != st_q && !expire) |=> (st_q == $past(st_q))) // RULE_07
        else $error("delayed output changed before delay ran out");
    delay_full_a: assert property (($changed(st_q) && $past(delayed)) |-> ($past(cnt_q) == CNT_W'(DELAY_CYC - 1))) // RULE_08
        else $error("delayed output changed without full count");
    delay_done_c: cover property (ce && delayed && expire && raw != st_q);
endmodule

//--- ocs_drive_model.sv
`timescale 1ns/10ps
module ocs_drive_model (
    // clock
    input wire logic aclk,
    // wanted drive status
    input wire logic [12:0] flg_set,
    input wire logic [10:0][15:0] val_set,
    // status seen by the selector
    output logic [12:0] flg = '0,
    output logic [10:0][15:0] val = '0
);
    // current is given in percent of rated, analog input kept unipolar
    always_ff @(posedge aclk) begin
        flg <= flg_set;
        val <= val_set;
    end
endmodule

//--- test_output_condition_selector.sv
`timescale 1ns/10ps
module test_output_condition_selector import ocs_pkg::*;;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, relay1_out, relay2_out, digital_out1, digital_out2;
    logic [1:0] bresp, rresp, r;
    logic [12:0] flg_set = 0, flg;
    logic [10:0][15:0] val_set = '0, val;
    logic power_ok, drive_ready, fault_active, motor_powered, reverse_cmd, overload_active, ramp_reg_active;
    logic restart_exceeded, unrecoverable_trip, brake_coil_control, control_module_overheat, comm_loss, logic_in1;
    logic [15:0] out_freq, cmd_freq, out_current, dc_bus_volts, analog_v, analog_v_mag;
    logic [15:0] analog_ma, pf_angle, thermal_count, drive_temp, trip_temp;
    int n_errors = 0, comparisons = 0;
    localparam logic [4:0] SIMPLE [6] = '{5'h02, 5'h03, 5'h09, 5'h0f, 5'h11, 5'h14};
    localparam int SBIT [6] = '{9, 8, 5, 3, 2, 0};
    localparam logic [4:0] DLY [7] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0b};
    localparam int DIDX [7] = '{7, 6, 10, 8, 7, 6, 3};
    assign {power_ok, drive_ready, fault_active, motor_powered, reverse_cmd, overload_active, ramp_reg_active,
        restart_exceeded, unrecoverable_trip, brake_coil_control, control_module_overheat, comm_loss,
        logic_in1} = flg;
    assign {out_freq, cmd_freq, out_current, dc_bus_volts, analog_v, analog_v_mag, analog_ma, pf_angle,
        thermal_count, drive_temp, trip_temp} = val;
    always #5 aclk = ~aclk;
    ocs_drive_model i_model (.aclk(aclk), .flg_set(flg_set), .val_set(val_set), .flg(flg), .val(val));
    ocs_top #(.DELAY_CYC(8)) i_dut (.*);
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(input int i);
        if (i >= 40) begin
            n_errors++;
            $display("[ERR] handshake expected answer seen timeout");
            close_out();
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dd);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dd;
        wstrb <= 4'hf;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 0;
        tmo(i);
    endtask
    task automatic rd(input logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 0;
        tmo(i);
    endtask
    initial begin
        int i;
        cyc(6);
        aresetn <= 1;
        cyc(2);
        for (i = 0; i < 4; i++) begin
            rd(ADDR_CH0 + 8'(4 * i));
            chk("chan reset", CH_RST[i], d);
        end
        rd(ADDR_CTRL);
        chk("ctrl reset", CTRL_RST, d);
        rd(8'h18);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(8'h18, 32'h1);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(8'h04, 32'h0f000006);
        rd(8'h04);
        chk("fraction clamp", 32'h09000006, d);
        $display("test registers ended");
        flg_set <= 13'h1800;
        cyc(5);
        chk("ready on", 32'h1, relay1_out);
        flg_set[10] <= 1;
        cyc(5);
        chk("fault off", 32'h0, relay1_out);
        flg_set <= 0;
        for (i = 0; i < 6; i++) begin
            wr(ADDR_CH0, {27'h0, SIMPLE[i]});
            cyc(5);
            chk("flag off", 32'h0, relay1_out);
            flg_set[SBIT[i]] <= 1;
            cyc(5);
            chk("flag on", 32'h1, relay1_out);
            flg_set <= 0;
        end
        wr(ADDR_CH0, 32'h1);
        val_set[9] <= 16'h01f4;
        val_set[10] <= 16'h01f6;
        cyc(6);
        chk("speed on", 32'h1, relay1_out);
        val_set[10] <= 16'h01eb;
        cyc(6);
        chk("speed band", 32'h1, relay1_out);
        val_set[10] <= 16'h01e9;
        cyc(6);
        chk("speed off", 32'h0, relay1_out);
        val_set <= '0;
        wr(ADDR_CH0, 32'h12);
        cyc(5);
        chk("keypad on", 32'h1, relay1_out);
        wr(ADDR_CTRL, 32'h00490303);
        cyc(5);
        chk("keypad off", 32'h0, relay1_out);
        chk("polarity 3", 32'h3, {30'h0, digital_out2, digital_out1});
        wr(ADDR_CH0, 32'h0e);
        cyc(5);
        chk("nonrec off", 32'h0, relay1_out);
        flg_set[4] <= 1;
        cyc(5);
        chk("nonrec on", 32'h1, relay1_out);
        flg_set <= 0;
        wr(ADDR_CTRL, 32'h1);
        cyc(5);
        chk("polarity 1", 32'h1, {30'h0, digital_out2, digital_out1});
        wr(ADDR_CH0, 32'h0d);
        cyc(5);
        chk("direct off", 32'h0, relay1_out);
        wr(ADDR_CH0, 32'h10d);
        cyc(5);
        chk("direct on", 32'h1, relay1_out);
        $display("test conditions ended");
        for (i = 0; i < 7; i++) begin
            wr(8'h04, 32'h03000500 | {27'h0, DLY[i]});
            if (i < 2) flg_set[DIDX[i]] <= 1;
            else val_set[DIDX[i]] <= 16'h0036;
            cyc(3);
            chk("delay hold", 32'h0, relay2_out);
            cyc(15);
            chk("delay on", 32'h1, relay2_out);
            flg_set <= 0;
            val_set[DIDX[i]] <= 16'h0035;
            cyc(3);
            chk("release hold", 32'h1, relay2_out);
            cyc(15);
            chk("release", 32'h0, relay2_out);
        end
        chk("relay1 kept", 32'h1, relay1_out);
        rd(ADDR_STAT);
        chk("status", 32'h000000c5, d);
        wr(ADDR_CH0, 32'h0c);
        wr(ADDR_CTRL, 32'h9);
        cyc(6);
        chk("loss on", 32'h1, relay1_out);
        val_set[5] <= 16'h000e;
        cyc(6);
        chk("loss hold", 32'h1, relay1_out);
        val_set[5] <= 16'h000f;
        cyc(6);
        chk("loss off", 32'h0, relay1_out);
        ce <= 0;
        val_set[3] <= 16'h0036;
        cyc(20);
        chk("ce freeze", 32'h0, relay2_out);
        ce <= 1;
        cyc(15);
        chk("ce resume", 32'h1, relay2_out);
        $display("test delays ended");
        close_out();
    end
endmodule
